// >>> hdl/bst_pkg.sv
// Purpose: Constants and types for the boundary-scan access port.
// Assumes: One system clock samples the test pins.
// Notes: Instruction codes follow the three-bit decode.
package bst_pkg;
   localparam int IR_W = 3;
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   localparam logic [2:0] IR_RESET = 3'h7;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_SAMPLE = 3'h1;
   localparam logic [2:0] INS_UNUSED = 3'h2;
   localparam logic [2:0] INS_PROBE = 3'h3;
   localparam logic [2:0] INS_USER = 3'h4;
   localparam logic [2:0] INS_HIGHZ = 3'h5;
   localparam logic [2:0] INS_CLAMP = 3'h6;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] SYNC_RST = 2'h3;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } bst_state_t;

   typedef enum logic [1:0] {
      SEL_BYPASS, SEL_BOUNDARY, SEL_PROBE, SEL_USER
   } bst_sel_t;
endpackage

// >>> hdl/bst_tap.sv
// Purpose: Test access port controller with three-bit instruction register.
// Assumes: Test clock is sampled by i_clk; data registers other than bypass live outside.
// Notes: Scan-out bits pass a two-entry buffer toward the output pin.
`timescale 1ns/1ps
module bst_tap (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Configuration fuse.
   input wire logic i_fuse_en,
   // Test pins.
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe_n,
   // Serial data from the outside data registers.
   input wire logic i_dr_tdo,
   // Control toward data registers.
   output logic o_dr_capture,
   output logic o_dr_shift,
   output logic o_dr_update,
   output logic o_dr_tdi,
   output logic [1:0] o_dr_sel,
   output logic o_highz,
   output logic o_clamp,
   output logic o_extest,
   output logic [2:0] o_instr,
   output logic o_test_reset,
   // User I/O release.
   output logic o_pins_user
);
   logic [2:0] tck_sync_ff, nxt_tck_sync;
   logic [1:0] tms_sync_ff, nxt_tms_sync;
   logic [1:0] tdi_sync_ff, nxt_tdi_sync;
   logic [1:0] fuse_sync_ff, nxt_fuse_sync;
   logic rise, fall, tms_s, tdi_s, fuse_s;
   bst_pkg::bst_state_t state_ff, nxt_state;
   logic [2:0] ir_sh_ff, nxt_ir_sh;
   logic [2:0] ir_ff, nxt_ir;
   logic byp_ff, nxt_byp;
   logic [1:0] buf_cnt_ff, nxt_buf_cnt;
   logic [1:0] buf_ff, nxt_buf;
   logic tdo_ff, nxt_tdo;
   logic oe_n_ff, nxt_oe_n;
   logic fall_ff, nxt_fall;
   logic cap_ff, nxt_cap, shf_ff, nxt_shf, upd_ff, nxt_upd, dtdi_ff, nxt_dtdi;
   logic [1:0] sel_ff, nxt_sel;
   logic hz_ff, nxt_hz, cl_ff, nxt_cl, ex_ff, nxt_ex, trst_ff, nxt_trst, user_ff, nxt_user;
   bst_pkg::bst_sel_t sel;
   logic serial_bit, push, pop, in_ready, out_valid, shifting;

   // Only the last two synchroniser stages feed the edge detector.
   always_comb begin
      nxt_tck_sync = {tck_sync_ff[1:0], i_tck};
      nxt_tms_sync = {tms_sync_ff[0], i_tms};
      nxt_tdi_sync = {tdi_sync_ff[0], i_tdi};
      nxt_fuse_sync = {fuse_sync_ff[0], i_fuse_en};
      rise = tck_sync_ff[1] & ~tck_sync_ff[2];
      fall = ~tck_sync_ff[1] & tck_sync_ff[2];
      tms_s = tms_sync_ff[1];
      tdi_s = tdi_sync_ff[1];
      fuse_s = fuse_sync_ff[1];
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tck_sync_ff <= 3'h0;
         tms_sync_ff <= bst_pkg::SYNC_RST;
         tdi_sync_ff <= bst_pkg::SYNC_RST;
         fuse_sync_ff <= 2'h0;
      end else begin
         tck_sync_ff <= nxt_tck_sync;
         tms_sync_ff <= nxt_tms_sync;
         tdi_sync_ff <= nxt_tdi_sync;
         fuse_sync_ff <= nxt_fuse_sync;
      end
   end

   // Controller graph; a dead fuse pins it in reset so user I/O sees nothing.
   always_comb begin
      nxt_state = state_ff;
      if (!fuse_s) begin
         nxt_state = bst_pkg::ST_RESET;
      end else if (rise) begin
         case (state_ff)
            bst_pkg::ST_RESET: nxt_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR: nxt_state = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR: nxt_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR: nxt_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_PAU_DR: nxt_state = tms_s ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
            bst_pkg::ST_EX2_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UPD_DR: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR: nxt_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR: nxt_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR: nxt_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_PAU_IR: nxt_state = tms_s ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
            bst_pkg::ST_EX2_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UPD_IR: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            default: nxt_state = bst_pkg::ST_RESET;
         endcase
      end
   end

   // Instruction decode toward the data register selection.
   always_comb begin
      case (ir_ff)
         bst_pkg::INS_EXTEST: sel = bst_pkg::SEL_BOUNDARY;
         bst_pkg::INS_SAMPLE: sel = bst_pkg::SEL_BOUNDARY;
         bst_pkg::INS_PROBE: sel = bst_pkg::SEL_PROBE;
         bst_pkg::INS_USER: sel = bst_pkg::SEL_USER;
         bst_pkg::INS_HIGHZ: sel = bst_pkg::SEL_BYPASS;
         bst_pkg::INS_CLAMP: sel = bst_pkg::SEL_BYPASS;
         bst_pkg::INS_UNUSED: sel = bst_pkg::SEL_BYPASS;
         default: sel = bst_pkg::SEL_BYPASS;
      endcase
   end

   // Instruction and bypass registers.
   always_comb begin
      nxt_ir_sh = ir_sh_ff;
      nxt_ir = ir_ff;
      nxt_byp = byp_ff;
      if (state_ff == bst_pkg::ST_RESET) begin
         nxt_ir = bst_pkg::IR_RESET;
      end
      if (rise) begin
         if (state_ff == bst_pkg::ST_CAP_IR) begin
            nxt_ir_sh = bst_pkg::IR_CAPTURE;
         end else if (state_ff == bst_pkg::ST_SH_IR) begin
            nxt_ir_sh = {tdi_s, ir_sh_ff[2:1]};
         end
         if (sel == bst_pkg::SEL_BYPASS) begin
            if (state_ff == bst_pkg::ST_CAP_DR) begin
               nxt_byp = 1'b0;
            end else if (state_ff == bst_pkg::ST_SH_DR) begin
               nxt_byp = tdi_s;
            end
         end
      end
      if (fall && state_ff == bst_pkg::ST_UPD_IR) begin
         nxt_ir = ir_sh_ff;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= bst_pkg::ST_RESET;
         ir_sh_ff <= bst_pkg::IR_CAPTURE;
         ir_ff <= bst_pkg::IR_RESET;
         byp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ir_sh_ff <= nxt_ir_sh;
         ir_ff <= nxt_ir;
         byp_ff <= nxt_byp;
      end
   end

   // Bits leave on the test clock fall and reach the pin one clock later through the buffer.
   // The pin never stalls, so the second entry is never filled, even with a fall in every clock.
   always_comb begin
      if (state_ff == bst_pkg::ST_SH_IR) begin
         serial_bit = ir_sh_ff[0];
      end else if (sel == bst_pkg::SEL_BYPASS) begin
         serial_bit = byp_ff;
      end else begin
         serial_bit = i_dr_tdo;
      end
      shifting = state_ff == bst_pkg::ST_SH_IR || state_ff == bst_pkg::ST_SH_DR;
      in_ready = buf_cnt_ff != bst_pkg::BUF_DEPTH;
      out_valid = buf_cnt_ff != 2'h0;
      push = fall && in_ready && shifting;
      pop = out_valid;
      nxt_buf = buf_ff;
      nxt_buf_cnt = buf_cnt_ff;
      if (pop && push) begin
         nxt_buf = {serial_bit, buf_ff[1]};
         nxt_buf[0] = (buf_cnt_ff == 2'h1) ? serial_bit : buf_ff[1];
      end else if (pop) begin
         nxt_buf = {1'b0, buf_ff[1]};
         nxt_buf_cnt = buf_cnt_ff - 2'h1;
      end else if (push) begin
         nxt_buf[buf_cnt_ff[0]] = serial_bit;
         nxt_buf_cnt = buf_cnt_ff + 2'h1;
      end
      // A bit still queued when the fuse drops must not reappear once it is back.
      if (!fuse_s) begin
         nxt_buf_cnt = 2'h0;
      end
      nxt_tdo = pop ? buf_ff[0] : tdo_ff;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buf_ff <= 2'h0;
         buf_cnt_ff <= 2'h0;
         tdo_ff <= 1'b0;
      end else begin
         buf_ff <= nxt_buf;
         buf_cnt_ff <= nxt_buf_cnt;
         tdo_ff <= nxt_tdo;
      end
   end

   // Drive enable follows the fall by one clock, so it reaches the pin with the first bit.
   always_comb begin
      nxt_fall = fall;
      nxt_oe_n = oe_n_ff;
      if (fall_ff) begin
         nxt_oe_n = !shifting;
      end
      if (!fuse_s) begin
         nxt_oe_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fall_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         fall_ff <= nxt_fall;
         oe_n_ff <= nxt_oe_n;
      end
   end

   // Data register strobes are one-cycle pulses on the matching test clock edge.
   always_comb begin
      nxt_cap = rise && state_ff == bst_pkg::ST_CAP_DR;
      nxt_shf = rise && state_ff == bst_pkg::ST_SH_DR;
      nxt_upd = fall && state_ff == bst_pkg::ST_UPD_DR;
      nxt_dtdi = tdi_s;
      nxt_sel = sel;
      nxt_hz = ir_ff == bst_pkg::INS_HIGHZ;
      nxt_cl = ir_ff == bst_pkg::INS_CLAMP;
      nxt_ex = ir_ff == bst_pkg::INS_EXTEST;
      nxt_trst = state_ff == bst_pkg::ST_RESET;
      nxt_user = !fuse_s;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_ff <= 1'b0;
         shf_ff <= 1'b0;
         upd_ff <= 1'b0;
         dtdi_ff <= 1'b1;
         sel_ff <= 2'h0;
         hz_ff <= 1'b0;
         cl_ff <= 1'b0;
         ex_ff <= 1'b0;
         trst_ff <= 1'b1;
         user_ff <= 1'b1;
      end else begin
         cap_ff <= nxt_cap;
         shf_ff <= nxt_shf;
         upd_ff <= nxt_upd;
         dtdi_ff <= nxt_dtdi;
         sel_ff <= nxt_sel;
         hz_ff <= nxt_hz;
         cl_ff <= nxt_cl;
         ex_ff <= nxt_ex;
         trst_ff <= nxt_trst;
         user_ff <= nxt_user;
      end
   end

   always_comb begin
      o_tdo = tdo_ff;
      o_tdo_oe_n = oe_n_ff;
      o_dr_capture = cap_ff;
      o_dr_shift = shf_ff;
      o_dr_update = upd_ff;
      o_dr_tdi = dtdi_ff;
      o_dr_sel = sel_ff;
      o_highz = hz_ff;
      o_clamp = cl_ff;
      o_extest = ex_ff;
      o_instr = ir_ff;
      o_test_reset = trst_ff;
      o_pins_user = user_ff;
   end
endmodule

// >>> tb/bst_tap_chk.sv
// Purpose: Port-level checks of the boundary-scan access port.
// Assumes: Test pins change just after a system clock edge.
// Notes: Latency windows allow for the pin synchronisers.
`timescale 1ns/1ps
module bst_tap_chk (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Watched inputs.
   input wire logic i_fuse_en,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   // Watched outputs.
   input wire logic o_tdo,
   input wire logic o_tdo_oe_n,
   input wire logic o_dr_capture,
   input wire logic o_dr_shift,
   input wire logic o_dr_update,
   input wire logic o_dr_tdi,
   input wire logic [1:0] o_dr_sel,
   input wire logic o_highz,
   input wire logic o_clamp,
   input wire logic o_extest,
   input wire logic [2:0] o_instr,
   input wire logic o_test_reset,
   input wire logic o_pins_user
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic tck_ff;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   // Rises with mode select high; saturates so the count never wraps back to five.
   always_comb begin
      nxt_cnt = cnt_ff;
      if (i_tck && !tck_ff) begin
         nxt_cnt = !i_tms ? 3'h0 : cnt_ff + 3'(cnt_ff != 3'h7);
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tck_ff <= 1'b0;
         cnt_ff <= 3'h0;
      end else begin
         tck_ff <= i_tck;
         cnt_ff <= nxt_cnt;
      end
   end
   reset_instr_a: assert property ($past(o_test_reset) && o_test_reset |-> o_instr == 3'h7)
      else $error("instruction not bypass in reset");
   fuse_off_a: assert property (!i_fuse_en [*7] |-> o_pins_user && o_test_reset)
      else $error("fuse off did not release pins");
   pulse_one_a: assert property (o_dr_capture || o_dr_shift || o_dr_update |->
      $onehot({o_dr_capture, o_dr_shift, o_dr_update}) ##1 !(o_dr_capture || o_dr_update))
      else $error("data register pulse malformed");
   decode_out_a: assert property (o_instr == $past(o_instr) && o_instr == $past(o_instr, 2) |->
      {o_highz, o_clamp, o_extest} == {o_instr == 3'h5, o_instr == 3'h6, o_instr == 3'h0})
      else $error("instruction decode wrong");
   bypass_sel_a: assert property (o_instr inside {3'h2, 3'h5, 3'h6, 3'h7} &&
      o_instr == $past(o_instr, 2) |-> o_dr_sel == 2'h0)
      else $error("bypass path not selected");
   tdo_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
      else $error("scan output moved outside low phase");
   tms_reset_a: assert property (cnt_ff == 3'h5 |-> ##[0:8] o_test_reset)
      else $error("five high mode bits did not reset");
   dr_drive_a: assert property (o_dr_shift |-> !o_tdo_oe_n && !o_test_reset)
      else $error("output not driven while shifting");
   instr_fall_a: assert property ($changed(o_instr) && !o_test_reset |->
      !$past(i_tck, 2))
      else $error("instruction changed outside low phase");
   tdi_pass_a: assert property (o_dr_tdi == $past(i_tdi, 3))
      else $error("data input not passed to data registers");
endmodule
bind bst_tap bst_tap_chk i_chk (.i_clk, .i_rst_n, .i_fuse_en, .i_tck, .i_tms, .i_tdi, .o_tdo,
   .o_tdo_oe_n, .o_dr_capture, .o_dr_shift, .o_dr_update, .o_dr_tdi, .o_dr_sel, .o_highz,
   .o_clamp, .o_extest, .o_instr, .o_test_reset, .o_pins_user);

// >>> tb/bst_tester.sv
// Purpose: Behavioural tester that drives the test pins and reads scan output.
// Assumes: Each test clock half lasts four system clocks.
// Notes: A released output reads as the inverse of its last driven bit.
`timescale 1ns/1ps
module bst_tester (
   // Clock.
   input wire logic i_clk,
   // Scan output from the device.
   input wire logic i_tdo,
   input wire logic i_tdo_oe_n,
   // Test pins toward the device.
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi
);
   logic last_tdo = 1'b0;
   logic line_tdo;
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   always @(posedge i_clk) begin
      if (i_tdo_oe_n === 1'b0) begin
         last_tdo <= i_tdo;
      end
   end
   // A floating line must not pass for a clean copy of the last bit.
   assign line_tdo = (i_tdo_oe_n === 1'b0) ? i_tdo : ~last_tdo;
   task automatic scan(input logic [15:0] m, input logic [15:0] d, input int n,
      output logic [15:0] q);
      q = 16'h0;
      for (int i = 0; i < n; i++) begin
         o_tms = m[i];
         o_tdi = d[i];
         repeat (4) @(posedge i_clk);
         #1;
         q[i] = line_tdo;
         o_tck = 1'b1;
         repeat (4) @(posedge i_clk);
         #1;
         o_tck = 1'b0;
      end
   endtask
endmodule

// >>> tb/tb.sv
// Purpose: Self-checking bench for the boundary-scan access port.
// Assumes: The tester model drives the test pins at an 80 ns test clock.
// Notes: Outside data registers are stood in for by one bit, held at 0 and later at 1.
`timescale 1ns/1ps
module tb;
   logic i_clk, i_rst_n, i_fuse_en, i_dr_tdo, i_tck, i_tms, i_tdi;
   logic o_tdo, o_tdo_oe_n, o_dr_capture, o_dr_shift, o_dr_update, o_dr_tdi;
   logic o_highz, o_clamp, o_extest, o_test_reset, o_pins_user;
   logic [1:0] o_dr_sel;
   logic [2:0] o_instr;
   int fails = 0;
   int compares = 0;
   int pulses = 0;
   // Expected register choice, two bits a code, code 0 lowest.
   localparam logic [15:0] SEL_TAB = 16'h0385;
   bst_tap i_bst_tap (.i_clk, .i_rst_n, .i_fuse_en, .i_tck, .i_tms, .i_tdi, .o_tdo,
      .o_tdo_oe_n, .i_dr_tdo, .o_dr_capture, .o_dr_shift, .o_dr_update, .o_dr_tdi,
      .o_dr_sel, .o_highz, .o_clamp, .o_extest, .o_instr, .o_test_reset, .o_pins_user);
   bst_tester i_bst_tester (.i_clk, .i_tdo(o_tdo), .i_tdo_oe_n(o_tdo_oe_n), .o_tck(i_tck),
      .o_tms(i_tms), .o_tdi(i_tdi));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      pulses <= pulses + int'(o_dr_capture) + int'(o_dr_shift) + int'(o_dr_update);
   end
   task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic settle();
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic t_power();
      logic [15:0] q;
      settle();
      chk("power_instr", o_instr, bst_pkg::IR_RESET);
      chk("power_reset", 3'(o_test_reset), 3'h1);
      chk("power_oe_n", 3'(o_tdo_oe_n), 3'h1);
      i_bst_tester.scan(16'h0000, 16'hffff, 1, q);
      $display("test power done");
   endtask
   task automatic t_codes();
      logic [15:0] q;
      int base;
      base = pulses;
      for (int c = 0; c < 8; c++) begin
         i_bst_tester.scan(16'h00c3, 16'hff8f | 16'(c << 4), 9, q);
         chk("capture", q[6:4], bst_pkg::IR_CAPTURE);
         chk("instr", o_instr, 3'(c));
         chk("sel", 3'(o_dr_sel), 3'(SEL_TAB[2 * c +: 2]));
         chk("decode", {o_highz, o_clamp, o_extest}, {c == 5, c == 6, c == 0});
      end
      chk("ir_pulses", 3'(pulses - base), 3'h0);
      $display("test codes done");
   endtask
   task automatic t_dr();
      logic [15:0] q;
      int base;
      i_bst_tester.scan(16'h00c3, 16'hffff, 9, q);
      base = pulses;
      i_bst_tester.scan(16'h0031, 16'hffff, 7, q);
      chk("bypass", 3'(q[4:3]), 3'h2);
      chk("dr_pulses", 3'(pulses - base), 3'h4);
      i_dr_tdo = 1'b1;
      i_bst_tester.scan(16'h00c3, 16'hff9f, 9, q);
      i_bst_tester.scan(16'h0031, 16'hffff, 7, q);
      chk("boundary", 3'(q[4:3]), 3'h3);
      $display("test data done");
   endtask
   task automatic t_tms();
      logic [15:0] q;
      i_bst_tester.scan(16'h00f3, 16'hffff, 8, q);
      settle();
      chk("early_reset", 3'(o_test_reset), 3'h0);
      i_bst_tester.scan(16'h0007, 16'hffff, 3, q);
      settle();
      chk("tms_reset", 3'(o_test_reset), 3'h1);
      chk("instr", o_instr, bst_pkg::IR_RESET);
      i_bst_tester.scan(16'h0000, 16'hffff, 1, q);
      $display("test mode reset done");
   endtask
   task automatic t_fuse();
      i_fuse_en = 1'b0;
      repeat (4) settle();
      chk("pins_user", 3'(o_pins_user), 3'h1);
      chk("fuse_reset", 3'(o_test_reset), 3'h1);
      chk("oe_n", 3'(o_tdo_oe_n), 3'h1);
      i_fuse_en = 1'b1;
      repeat (4) settle();
      chk("pins_back", 3'(o_pins_user), 3'h0);
      $display("test fuse done");
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_fuse_en = 1'b1;
      i_dr_tdo = 1'b0;
      repeat (12) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      t_power();
      t_codes();
      t_dr();
      t_tms();
      t_fuse();
      conclude();
   end
   // A hung run is cut short and counted as a failure.
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule
